// [rtl/oscillator_source_select.sv]
// Purpose: system clock source selection, start-up counter, fail monitor, clock out
// Assumes: pins sampled synchronous to pclk; analog amplifier and real muxing outside
// Notes: clock pins are seen as levels; their edges are counted in the pclk domain
`timescale 1ns/1ps
`include "oscillator_source_select_params.svh"

// Contract
// - reset source comes from reset source field
// - external mode field picks six modes
// - lost external clock falls back to internal
// - crystal modes wait 1024 primary clock edges
// - external logic clock skips start-up count
// - stopped clock halts logic, keeps state
// - code 010 routes external through PLL
// - fast internal offers nine frequencies
// - slow internal fixed at 31 kHz
// - clock output is system clock over four
// - software writes switch source and divider
// - primary pin clocks, secondary pin free
// - auxiliary oscillator selectable at run time
// - crystal modes drive distinct gain controls
// - divider spans one to 512
// - codes 110 and 000 start 1/64 MHz
module oscillator_source_select (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_enable,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire oscillator_source_select_pkg::apb_word_t pwdata,
  output oscillator_source_select_pkg::apb_word_t prdata,
  output logic pready,
  output logic pslverr,
  input wire logic device_reset,
  input wire logic wake_from_sleep,
  input wire logic primary_clock_in_pin,
  input wire logic system_clock_in,
  output logic [2:0] system_source,
  output logic pll_enable,
  output logic primary_pin_is_clock,
  output logic gain_low,
  output logic gain_medium,
  output logic gain_high,
  output logic clock_released,
  output logic clock_fail_monitor,
  output logic [6:0] fast_internal_mhz,
  output logic [3:0] divider_log2,
  output logic secondary_clock_pin_out,
  output logic secondary_clock_pin_oe_n,
  output logic divided_clock_output,
  output logic irq
);
  import oscillator_source_select_pkg::*;

  typedef struct packed {
    logic [2:0] reset_clock_source_field;
    ext_mode_e external_oscillator_mode_field;
    logic clock_output_enable;
    logic [2:0] new_clock_source_field;
    logic [3:0] new_clock_divider_field;
    logic [3:0] internal_frequency_select;
    logic [2:0] cur_src;
    startup_e su_state;
    logic [10:0] startup_cycle_counter;
    logic [7:0] fail_cnt;
    logic failed;
    logic prim_prev;
    logic sys_prev;
    logic [1:0] cko_cnt;
    logic cko;
    logic [2:0] int_status;
    logic [2:0] int_enable;
    apb_word_t rdata;
  } state_s;

  state_s state_reg;
  state_s state_next;
  logic wr_acc;
  logic rd_setup;
  logic mapped;
  logic prim_edge;
  logic sys_edge;
  logic is_ext;
  logic is_crystal;
  logic restart;
  logic [2:0] events;

  // source and mode decode shared by logic and outputs
  // external source decode, direct or through the pll
  assign is_ext = (state_reg.cur_src == `SRC_EXT) || (state_reg.cur_src == `SRC_EXT_PLL);
  assign is_crystal = (state_reg.external_oscillator_mode_field == watch_crystal_mode)
      || (state_reg.external_oscillator_mode_field == medium_gain_crystal_mode)
      || (state_reg.external_oscillator_mode_field == high_gain_crystal_mode);
  assign prim_edge = primary_clock_in_pin && !state_reg.prim_prev;
  assign sys_edge = system_clock_in && !state_reg.sys_prev;

  // apb decode: zero wait states, error on unmapped offsets
  assign wr_acc = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign mapped = (paddr == `OFS_CONFIG) || (paddr == `OFS_CONTROL) || (paddr == `OFS_FREQ)
      || (paddr == `OFS_STATUS) || (paddr == `OFS_INT_STATUS) || (paddr == `OFS_INT_CLEAR)
      || (paddr == `OFS_INT_ENABLE);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // next state of the whole block
  always_comb begin
    state_next = state_reg;
    restart = 1'b0;
    events = 3'h0;
    state_next.prim_prev = primary_clock_in_pin;
    state_next.sys_prev = system_clock_in;
    // register writes
    if (wr_acc) begin
      case (paddr)
        `OFS_CONFIG: begin
          state_next.reset_clock_source_field = pwdata[`CFG_RST_SRC_LSB +: 3];
          state_next.external_oscillator_mode_field = ext_mode_e'(pwdata[`CFG_EXT_MODE_LSB +: 3]);
          state_next.clock_output_enable = pwdata[`CFG_DIVIDED_CLOCK_OUTPUT_BIT];
        end
        `OFS_CONTROL: begin
          state_next.new_clock_source_field = pwdata[`CTL_SRC_LSB +: 3];
          state_next.new_clock_divider_field = (pwdata[`CTL_DIV_LSB +: 4] > `DIV_MAX) ?
              `DIV_MAX : pwdata[`CTL_DIV_LSB +: 4];
          state_next.cur_src = pwdata[`CTL_SRC_LSB +: 3];
          state_next.failed = 1'b0;
          events[`INT_SWITCH_BIT] = 1'b1;
          restart = 1'b1;
        end
        `OFS_FREQ: begin
          // nine codes, larger ones clamp to 64 MHz
          state_next.internal_frequency_select = (pwdata[3:0] > `FREQ_64M) ?
              `FREQ_64M : pwdata[3:0];
        end
        `OFS_INT_ENABLE: state_next.int_enable = pwdata[2:0];
        default: begin
        end
      endcase
    end
    if (device_reset) begin
      state_next.cur_src = state_reg.reset_clock_source_field;
      state_next.new_clock_source_field = state_reg.reset_clock_source_field;
      state_next.new_clock_divider_field = `DIV_RESET;
      state_next.failed = 1'b0;
      restart = 1'b1;
      if (state_reg.reset_clock_source_field == `SRC_HF_1M) begin
        state_next.internal_frequency_select = `FREQ_1M;
      end else if (state_reg.reset_clock_source_field == `SRC_HF_64M) begin
        state_next.internal_frequency_select = `FREQ_64M;
      end
    end
    if (wake_from_sleep) begin
      restart = 1'b1;
    end
    // start-up counter
    case (state_reg.su_state)
      startup_ready: begin
        if (restart) begin
          state_next.startup_cycle_counter = 11'd0;
          state_next.su_state = startup_counting;
        end
      end
      startup_counting: begin
        if (restart) begin
          state_next.startup_cycle_counter = 11'd0;
        end else if (!is_ext || !is_crystal) begin
          state_next.su_state = startup_ready;
        end else if (prim_edge) begin
          if (state_reg.startup_cycle_counter == `STARTUP_COUNT - 11'd1) begin
            state_next.su_state = startup_ready;
            events[`INT_STARTUP_BIT] = 1'b1;
          end else begin
            state_next.startup_cycle_counter = state_reg.startup_cycle_counter + 11'd1;
          end
        end
      end
      default: state_next.su_state = startup_ready;
    endcase
    // fail monitor on released external clock
    if (is_ext && (state_reg.su_state == startup_ready) && !restart) begin
      if (prim_edge) begin
        state_next.fail_cnt = 8'd0;
      end else if (state_reg.fail_cnt == 8'(`FAIL_CYCLES - 1)) begin
        state_next.fail_cnt = 8'd0;
        state_next.failed = 1'b1;
        state_next.cur_src = `SRC_HF_64M;
        events[`INT_FAIL_BIT] = 1'b1;
      end else begin
        state_next.fail_cnt = state_reg.fail_cnt + 8'd1;
      end
    end else begin
      state_next.fail_cnt = 8'd0;
    end
    // clock out toggles every second edge
    if (sys_edge) begin
      if (state_reg.cko_cnt == `DIVIDED_CLOCK_OUTPUT_HALF) begin
        state_next.cko_cnt = 2'd0;
        state_next.cko = !state_reg.cko;
      end else begin
        state_next.cko_cnt = state_reg.cko_cnt + 2'd1;
      end
    end
    // sticky flags: a new event beats a clear in the same cycle
    state_next.int_status = state_reg.int_status | events;
    if (wr_acc && (paddr == `OFS_INT_CLEAR)) begin
      state_next.int_status = (state_reg.int_status & ~pwdata[2:0]) | events;
    end
    // read data captured in the setup phase
    if (rd_setup) begin
      state_next.rdata = 32'h0;
      case (paddr)
        `OFS_CONFIG: state_next.rdata[6:0] = {state_reg.clock_output_enable,
            state_reg.external_oscillator_mode_field, state_reg.reset_clock_source_field};
        `OFS_CONTROL: state_next.rdata[7:0] = {state_reg.new_clock_divider_field,
            1'b0, state_reg.new_clock_source_field};
        `OFS_FREQ: state_next.rdata[3:0] = state_reg.internal_frequency_select;
        `OFS_STATUS: state_next.rdata[5:0] = {state_reg.failed,
            (state_reg.su_state == startup_counting), 1'b0, state_reg.cur_src};
        `OFS_INT_STATUS: state_next.rdata[2:0] = state_reg.int_status;
        `OFS_INT_ENABLE: state_next.rdata[2:0] = state_reg.int_enable;
        default: state_next.rdata = 32'h0;
      endcase
    end
  end

  // state register; low clock enable freezes everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
      state_reg.reset_clock_source_field <= `CFG_RST_SRC_RESET;
      state_reg.external_oscillator_mode_field <= ext_mode_e'(`CFG_EXT_MODE_RESET);
      state_reg.clock_output_enable <= `CFG_DIVIDED_CLOCK_OUTPUT_RESET;
      state_reg.new_clock_source_field <= `CFG_RST_SRC_RESET;
      state_reg.new_clock_divider_field <= `DIV_RESET;
      state_reg.internal_frequency_select <= `FREQ_RESET;
      state_reg.cur_src <= `CFG_RST_SRC_RESET;
      state_reg.su_state <= startup_counting;
    end else if (clk_enable) begin
      state_reg <= state_next;
    end
  end

  // outputs
  assign prdata = state_reg.rdata;
  assign system_source = state_reg.cur_src;
  assign pll_enable = state_reg.cur_src == `SRC_EXT_PLL;
  // primary pin is the clock input
  assign primary_pin_is_clock = is_ext;
  // one gain control per crystal mode
  assign gain_low = is_ext && (state_reg.external_oscillator_mode_field == watch_crystal_mode);
  assign gain_medium = is_ext
      && (state_reg.external_oscillator_mode_field == medium_gain_crystal_mode);
  assign gain_high = is_ext && (state_reg.external_oscillator_mode_field == high_gain_crystal_mode);
  // crystal clock gated until count completes
  assign clock_released = state_reg.su_state == startup_ready;
  assign clock_fail_monitor = state_reg.failed;
  assign divider_log2 = state_reg.new_clock_divider_field;
  assign divided_clock_output = state_reg.cko;
  // secondary pin drives clock out when clock output is enabled and no crystal owns it
  assign secondary_clock_pin_oe_n = !(state_reg.clock_output_enable && !(is_ext && is_crystal));
  assign secondary_clock_pin_out = state_reg.cko;
  assign irq = |(state_reg.int_status & state_reg.int_enable);

  // frequency code to MHz; slow oscillator has no select field
  always_comb begin
    case (state_reg.internal_frequency_select)
      4'h0: fast_internal_mhz = 7'd1;
      4'h1: fast_internal_mhz = 7'd2;
      4'h2: fast_internal_mhz = 7'd4;
      4'h3: fast_internal_mhz = 7'd8;
      4'h4: fast_internal_mhz = 7'd12;
      4'h5: fast_internal_mhz = 7'd16;
      4'h6: fast_internal_mhz = 7'd32;
      4'h7: fast_internal_mhz = 7'd48;
      default: fast_internal_mhz = 7'd64;
    endcase
  end

  // checks
  // check
  startup_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_enable && prim_edge && is_ext && is_crystal && !restart
      && state_reg.su_state == startup_counting
      && state_reg.startup_cycle_counter == `STARTUP_COUNT - 11'd1)
    |=> (state_reg.su_state == startup_ready))
    else $error("start-up did not finish at full count");
  held_while_count_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg.su_state == startup_counting && is_ext && is_crystal
      && state_reg.startup_cycle_counter != `STARTUP_COUNT - 11'd1)
      |=> !clock_released)
    else $error("clock released during start-up");
  bypass_ext_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_enable && !restart && !is_crystal && state_reg.su_state == startup_counting)
      |=> clock_released)
    else $error("external logic clock delayed");
  fail_fallback_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(clock_fail_monitor) |-> (system_source == `SRC_HF_64M) && irq == (|(
      state_reg.int_status & state_reg.int_enable)) && state_reg.int_status[`INT_FAIL_BIT])
    else $error("fail without fallback");
  pll_route_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_enable && wr_acc && paddr == `OFS_CONTROL && !device_reset
      && pwdata[2:0] == `SRC_EXT_PLL |=> pll_enable && primary_pin_is_clock)
    else $error("pll not routed");
  reset_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_enable && device_reset |=> system_source == $past(state_reg.reset_clock_source_field))
    else $error("reset source not loaded");
  reset_freq_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_enable && device_reset && state_reg.reset_clock_source_field == `SRC_HF_1M
      |=> fast_internal_mhz == 7'd1)
    else $error("1 MHz start wrong");
  freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
    !clk_enable |=> $stable(state_reg))
    else $error("state moved while halted");
  divided_clock_output_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
    secondary_clock_pin_oe_n == (gain_low || gain_medium || gain_high
      || !state_reg.clock_output_enable))
    else $error("clock out drives a crystal pin");
  gain_onehot_a: assert property (@(posedge pclk) disable iff (!presetn)
    $onehot0({gain_low, gain_medium, gain_high}))
    else $error("gain controls overlap");
  div_range_a: assert property (@(posedge pclk) disable iff (!presetn)
    divider_log2 <= `DIV_MAX)
    else $error("divider out of range");
  wake_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_enable && wake_from_sleep |=> !clock_released && state_reg.startup_cycle_counter == 11'd0)
    else $error("wake did not restart count");
endmodule : oscillator_source_select

// [shared/oscillator_source_select_params.svh]
// Purpose: constants of the oscillator source selection block
// Assumes: pclk at 40 MHz
// Notes: offsets are byte addresses of 32-bit APB words
`ifndef OSCILLATOR_SOURCE_SELECT_PARAMS_SVH
`define OSCILLATOR_SOURCE_SELECT_PARAMS_SVH

// register offsets
`define OFS_CONFIG 8'h00
`define OFS_CONTROL 8'h04
`define OFS_FREQ 8'h08
`define OFS_STATUS 8'h0C
`define OFS_INT_STATUS 8'h10
`define OFS_INT_CLEAR 8'h14
`define OFS_INT_ENABLE 8'h18

// field positions
`define CFG_RST_SRC_LSB 0
`define CFG_EXT_MODE_LSB 3
`define CFG_DIVIDED_CLOCK_OUTPUT_BIT 6
`define CTL_SRC_LSB 0
`define CTL_DIV_LSB 4
`define INT_SWITCH_BIT 0
`define INT_FAIL_BIT 1
`define INT_STARTUP_BIT 2

// reset values
`define CFG_RST_SRC_RESET 3'h0
`define CFG_EXT_MODE_RESET 3'h0
`define CFG_DIVIDED_CLOCK_OUTPUT_RESET 1'h0
`define FREQ_RESET 4'h8
`define DIV_RESET 4'h0

// clock source codes of the reset and new source fields
`define SRC_HF_64M 3'h0
`define SRC_EXT_PLL 3'h2
`define SRC_AUX 3'h4
`define SRC_LF 3'h5
`define SRC_HF_1M 3'h6
`define SRC_EXT 3'h7

// frequency select codes for 1 MHz and 64 MHz, largest divider code
`define FREQ_1M 4'h0
`define FREQ_64M 4'h8
`define DIV_MAX 4'h9

// timing counts
`define STARTUP_COUNT 11'd1024
`define PCLK_MHZ 40
`define FAIL_TIME_NS 2000
`define FAIL_CYCLES ((`FAIL_TIME_NS * `PCLK_MHZ) / 1000)
`define DIVIDED_CLOCK_OUTPUT_HALF 2'd1

`endif

// [shared/oscillator_source_select_pkg.sv]
// Purpose: types of the oscillator source selection block
// Assumes: constants come from the params header
// Notes: enum codes count up from zero in declaration order
package oscillator_source_select_pkg;
  typedef enum logic [2:0] {
    ext_clock_high_power,
    ext_clock_medium_power,
    ext_clock_low_power,
    mode_unused,
    watch_crystal_mode,
    medium_gain_crystal_mode,
    high_gain_crystal_mode,
    mode_spare
  } ext_mode_e;
  typedef enum logic {
    startup_ready,
    startup_counting
  } startup_e;
  typedef logic [31:0] apb_word_t;
endpackage : oscillator_source_select_pkg

// [tb/clock_source_model.sv]
// Purpose: external clock source or resonator that feeds the primary pin
// Assumes: pin toggles every second pclk cycle while running
// Notes: a stopped source holds its last level, as a dead crystal would
`timescale 1ns/1ps
module clock_source_model (
  input wire logic pclk,
  input wire logic run,
  output logic pin,
  output logic sys_clk
);
  logic phase_reg = 1'b0;
  logic pin_reg = 1'b0;
  logic sys_reg = 1'b0;

  // system clock toggles every cycle, primary pin every second one while running
  always @(posedge pclk) begin
    sys_reg <= ~sys_reg;
    if (run) begin
      phase_reg <= ~phase_reg;
      if (phase_reg) pin_reg <= ~pin_reg;
    end
  end

  // both pins come from one shared process, so each has a single driver
  assign pin = pin_reg;
  assign sys_clk = sys_reg;
endmodule : clock_source_model

// [tb/oscillator_source_select_test.sv]
// Purpose: self-checking bench of the oscillator source selection block
// Assumes: zero wait state APB, primary clock from the source model
// Notes: reset values first, then table rows, start-up, fail and reload cases
`timescale 1ns/1ps
`include "oscillator_source_select_params.svh"
module oscillator_source_select_test;
  import oscillator_source_select_pkg::*;
  typedef struct packed {
    logic [2:0] src;
    logic [3:0] div;
    logic [3:0] freq;
    logic [6:0] mhz;
    logic [3:0] dlog;
  } row_s;
  row_s rows [9] = '{'{3'h0, 4'h0, 4'h0, 7'h01, 4'h0}, '{3'h2, 4'h1, 4'h1, 7'h02, 4'h1},
    '{3'h4, 4'h2, 4'h2, 7'h04, 4'h2}, '{3'h5, 4'h3, 4'h3, 7'h08, 4'h3},
    '{3'h6, 4'h4, 4'h4, 7'h0C, 4'h4}, '{3'h7, 4'h5, 4'h5, 7'h10, 4'h5},
    '{3'h0, 4'h8, 4'h6, 7'h20, 4'h8}, '{3'h2, 4'h9, 4'h7, 7'h30, 4'h9},
    '{3'h7, 4'hF, 4'hF, 7'h40, 4'h9}};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_enable = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  apb_word_t pwdata = 32'h0;
  apb_word_t prdata;
  logic pready, pslverr, device_reset = 1'b0, wake = 1'b0, run = 1'b1, prim, sysclk;
  logic [2:0] system_source;
  logic pll_enable, pin_is_clock, gain_low, gain_medium, gain_high, clock_released;
  logic clock_fail_monitor, pin_out, pin_oe_n, divided_clock_output, irq;
  logic [6:0] fast_internal_mhz;
  logic [3:0] divider_log2;
  logic [31:0] rd;
  logic err, prev;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int t;

  oscillator_source_select uut (.pclk(pclk), .presetn(presetn), .clk_enable(clk_enable),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .device_reset(device_reset),
    .wake_from_sleep(wake), .primary_clock_in_pin(prim), .system_clock_in(sysclk),
    .system_source(system_source), .pll_enable(pll_enable),
    .primary_pin_is_clock(pin_is_clock), .gain_low(gain_low), .gain_medium(gain_medium),
    .gain_high(gain_high), .clock_released(clock_released),
    .clock_fail_monitor(clock_fail_monitor), .fast_internal_mhz(fast_internal_mhz),
    .divider_log2(divider_log2), .secondary_clock_pin_out(pin_out),
    .secondary_clock_pin_oe_n(pin_oe_n), .divided_clock_output(divided_clock_output),
    .irq(irq));

  clock_source_model src_model (.pclk(pclk), .run(run), .pin(prim), .sys_clk(sysclk));

  // 40 MHz clock
  always #12.5 pclk = ~pclk;

  // hang guard
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      errors++;
      stop_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
      errors++;
    end
  endtask : check

  // one APB transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask : apb

  // wait for k rising edges on the primary pin
  task automatic edges(input int k);
    int e;
    logic p;
    e = 0;
    p = prim;
    while (e < k) begin
      @(posedge pclk);
      if (prim && !p) e++;
      p = prim;
    end
    @(negedge pclk);
  endtask : edges

  task automatic pulse_reset(input logic wk);
    @(posedge pclk);
    if (wk) wake <= 1'b1;
    else device_reset <= 1'b1;
    @(posedge pclk);
    wake <= 1'b0;
    device_reset <= 1'b0;
    repeat (2) @(negedge pclk);
  endtask : pulse_reset

  task automatic stop_test();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  initial begin
    // outputs while reset is held
    repeat (6) @(negedge pclk);
    check({pin_oe_n, irq, system_source}, 5'h10);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `OFS_CONFIG, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, `OFS_FREQ, 32'h0);
    check(rd, 32'h8);
    check({clock_released, fast_internal_mhz}, 8'hC0);
    foreach (rows[i]) begin
      apb(1'b1, `OFS_FREQ, {28'h0, rows[i].freq});
      apb(1'b1, `OFS_CONTROL, {24'h0, rows[i].div, 1'b0, rows[i].src});
      check(system_source, rows[i].src);
      check(fast_internal_mhz, rows[i].mhz);
      check(divider_log2, rows[i].dlog);
      check(pll_enable, rows[i].src == 3'h2);
      check(pin_is_clock, rows[i].src == 3'h2 || rows[i].src == 3'h7);
      check({pready, pslverr}, 2'b10);
    end
    // control read back: last row source 7, divider clamped to 9
    apb(1'b0, `OFS_CONTROL, 32'h0);
    check(rd, 32'h97);
    // divided clock out in external logic clock mode
    apb(1'b1, `OFS_CONFIG, 32'h40);
    apb(1'b1, `OFS_CONTROL, 32'h7);
    check(pin_oe_n, 1'b0);
    t = 0;
    prev = divided_clock_output;
    repeat (64) begin
      @(negedge pclk);
      check(pin_out, divided_clock_output);
      if (divided_clock_output !== prev) t++;
      prev = divided_clock_output;
    end
    check(t >= 15 && t <= 17, 1'b1);
    // crystal modes hold the clock for the full count
    for (int m = 4; m <= 6; m++) begin
      apb(1'b1, `OFS_CONFIG, 32'h40 | (m << 3));
      apb(1'b1, `OFS_CONTROL, 32'h7);
      check({gain_low, gain_medium, gain_high}, 3'b100 >> (m - 4));
      check({pin_oe_n, clock_released}, 2'b10);
      edges(1020);
      check(clock_released, 1'b0);
      repeat (40) @(negedge pclk);
      check(clock_released, 1'b1);
    end
    // switch and start-up done flags are sticky
    apb(1'b0, `OFS_INT_STATUS, 32'h0);
    check(rd, 32'h5);
    pulse_reset(1'b1);
    check(clock_released, 1'b0);
    edges(1020);
    check(clock_released, 1'b0);
    apb(1'b1, `OFS_CONFIG, 32'h0);
    apb(1'b1, `OFS_CONTROL, 32'h7);
    @(posedge pclk);
    clk_enable <= 1'b0;
    run <= 1'b0;
    repeat (200) @(posedge pclk);
    clk_enable <= 1'b1;
    run <= 1'b1;
    repeat (20) @(negedge pclk);
    check({clock_fail_monitor, system_source}, 4'h7);
    // lost external clock falls back, interrupt raised, masked, cleared
    apb(1'b1, `OFS_INT_CLEAR, 32'h7);
    apb(1'b1, `OFS_INT_ENABLE, 32'h2);
    check(irq, 1'b0);
    @(posedge pclk);
    run <= 1'b0;
    repeat (60) @(negedge pclk);
    check(system_source, 3'h7);
    repeat (40) @(negedge pclk);
    check({irq, clock_fail_monitor, system_source}, 5'h18);
    apb(1'b0, `OFS_STATUS, 32'h0);
    check(rd, 32'h20);
    apb(1'b0, `OFS_INT_STATUS, 32'h0);
    check(rd, 32'h2);
    apb(1'b1, `OFS_INT_ENABLE, 32'h0);
    check(irq, 1'b0);
    apb(1'b1, `OFS_INT_CLEAR, 32'h2);
    apb(1'b1, `OFS_INT_ENABLE, 32'h2);
    check(irq, 1'b0);
    @(posedge pclk);
    run <= 1'b1;
    // device reset reloads the source field
    for (int c = 0; c < 3; c++) begin
      apb(1'b1, `OFS_CONFIG, c == 0 ? 32'h6 : c == 1 ? 32'h0 : 32'h2);
      pulse_reset(1'b0);
      check(system_source, c == 0 ? 3'h6 : c == 1 ? 3'h0 : 3'h2);
      check(pll_enable, c == 2);
      if (c < 2) check(fast_internal_mhz, c == 0 ? 7'h01 : 7'h40);
    end
    // unmapped offset and write-only clear register
    apb(1'b1, 8'h40, 32'hFFFFFFFF);
    check(err, 1'b1);
    apb(1'b0, 8'h40, 32'h0);
    check({err, rd}, {1'b1, 32'h0});
    apb(1'b0, `OFS_INT_CLEAR, 32'h0);
    check(rd, 32'h0);
    // a write while halted is lost
    @(posedge pclk);
    clk_enable <= 1'b0;
    apb(1'b1, `OFS_FREQ, 32'h3);
    @(posedge pclk);
    clk_enable <= 1'b1;
    @(negedge pclk);
    check(fast_internal_mhz, 7'h40);
    stop_test();
  end
endmodule : oscillator_source_select_test
